// file: swk_config.sv
// Selective-wake configuration registers, calibration and wake-frame matching
`timescale 1ns/1ps
// Behaviour
// - Control bit 7 enables oscillator calibration mode.
// - Recalibration unlocked only when key bits 6:5 equal 11.
// - Calibration trims oscillator from transmit data pin activity.
// - Option register writes accepted only while key equals 11.
// - Bit 4 gates bus time-out onto active-low interrupt pin.
// - Time-out flag sets only while selective wake enable input is high.
// - Selective wake enabled only while configuration-valid reads one.
// - Valid bit cleared on wake-up, power-on, or config data change.
// - Reserved bits read as zero.
// - Eight-bit time quanta per bit field.
// - Six-bit sampling point fraction field.
// - Reset loads a0 and 33; restart keeps timing registers.
// - Restart clears control low nibble, keeps upper nibble.
// - 29-bit identifier spread over four registers.
// - Standard identifier occupies identifier bits 28 to 18.
// - Extension bit selects 11 or 29 bit identifier.
// - Remote bit selects data frame or remote request.
module can_selective_wake_config
   import wake_cfg_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        resetn_i,
   input  wire logic        soft_reset_i,
   input  wire logic        restart_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [6:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic      [7:0]  reg_rdata_o,
   output logic             reg_rvalid_o,
   input  wire logic        wake_option_register_wr_i,
   input  wire logic [7:0]  wake_option_register_data_i,
   output logic      [7:0]  wake_option_register_o,
   input  wire logic        selective_wake_enable_i,
   input  wire logic        bus_timeout_event_i,
   input  wire logic        bus_timeout_clear_i,
   output logic             bus_timeout_flag_o,
   output logic             interrupt_out_n_o,
   input  wire logic        transmit_data_pin_i,
   output logic      [15:0] osc_trim_period_o,
   output logic             osc_trim_strobe_o,
   input  wire logic        wake_up_event_i,
   input  wire logic        frame_valid_i,
   input  wire logic [28:0] frame_id_i,
   input  wire logic        frame_ide_i,
   input  wire logic        frame_rtr_i,
   output logic             wake_up_frame_match_o,
   output logic             selective_wake_active_o,
   output logic             recal_unlocked_o,
   output logic      [7:0]  quanta_per_bit_o,
   output logic      [5:0]  sample_point_fraction_o
);

   wake_reg_if rif ();

   logic       cfg_wr;
   logic       key_ok;
   logic       wake_enabled;
   logic       clear_valid;
   logic       rd_pend;
   logic [28:0] cfg_id;

   function automatic logic [2:0] addr_index(input logic [6:0] a);
      addr_index = 3'(a - ADDR_CTRL);
   endfunction : addr_index

   function automatic logic in_map(input logic [6:0] a);
      in_map = (a >= ADDR_CTRL) && (a <= ADDR_ID_LOW);
   endfunction : in_map

   // ==========================================================
   // Register access
   assign rif.wr_en   = reg_wr_i && in_map(reg_addr_i);
   assign rif.wr_idx  = addr_index(reg_addr_i);
   assign rif.wr_data = reg_wdata_i;
   assign rif.rd_idx  = in_map(reg_addr_i) ? addr_index(reg_addr_i) : 3'd7;

   // Any write to timing or identifier data
   assign cfg_wr = rif.wr_en && (reg_addr_i != ADDR_CTRL);
   assign clear_valid = wake_up_event_i || cfg_wr;

   wake_reg_store u_store (
      .mclk_i        (mclk_i),
      .resetn_i      (resetn_i),
      .soft_reset_i  (soft_reset_i),
      .restart_i     (restart_i),
      .clear_valid_i (clear_valid),
      .bus           (rif.store)
   );

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_pend <= 1'b0;
      end else begin
         rd_pend <= reg_rd_i;
      end
   end

   assign reg_rdata_o  = rif.rd_data;
   assign reg_rvalid_o = rd_pend;

   // ==========================================================
   // Derived controls
   assign key_ok = rif.ctrl[CTRL_KEY_HI:CTRL_KEY_LO] == UNLOCK_KEY;
   assign recal_unlocked_o = key_ok;
   assign wake_enabled = rif.ctrl[CTRL_VALID_BIT] && selective_wake_enable_i;
   assign selective_wake_active_o = wake_enabled;
   assign quanta_per_bit_o = rif.quanta;
   assign sample_point_fraction_o = rif.sample[5:0];

   // ==========================================================
   // Option register, writable only with unlock key
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wake_option_register_o <= OPTION_RST;
      end else if (soft_reset_i) begin
         wake_option_register_o <= OPTION_RST;
      end else if (wake_option_register_wr_i && key_ok) begin
         wake_option_register_o <= wake_option_register_data_i;
      end
   end

   // ==========================================================
   // Bus time-out flag and interrupt
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus_timeout_flag_o <= 1'b0;
      end else if (bus_timeout_event_i && selective_wake_enable_i) begin
         bus_timeout_flag_o <= 1'b1;
      end else if (bus_timeout_clear_i) begin
         bus_timeout_flag_o <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         interrupt_out_n_o <= 1'b1;
      end else begin
         interrupt_out_n_o <= !(bus_timeout_flag_o && rif.ctrl[CTRL_TO_IRQ_BIT]);
      end
   end

   // ==========================================================
   // Oscillator calibration: measure transmit pin low-high periods
   cal_state_t  cal_state;
   logic [15:0] cal_cnt;
   logic        cal_run;

   assign cal_run = rif.ctrl[CTRL_CAL_MODE_BIT] && key_ok;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cal_state <= CAL_IDLE;
      end else if (!cal_run) begin
         cal_state <= CAL_IDLE;
      end else begin
         case (cal_state)
            CAL_IDLE: begin
               if (!transmit_data_pin_i) cal_state <= CAL_LOW;
            end
            CAL_LOW: begin
               if (transmit_data_pin_i) cal_state <= CAL_HIGH;
            end
            CAL_HIGH: begin
               if (!transmit_data_pin_i) cal_state <= CAL_LOW;
            end
            default: cal_state <= CAL_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cal_cnt           <= CAL_CNT_RST;
         osc_trim_period_o <= CAL_CNT_RST;
         osc_trim_strobe_o <= 1'b0;
      end else begin
         osc_trim_strobe_o <= 1'b0;
         if (!cal_run || cal_state == CAL_IDLE) begin
            cal_cnt <= CAL_CNT_RST;
         end else if (cal_state == CAL_HIGH && !transmit_data_pin_i) begin
            osc_trim_period_o <= cal_cnt + 16'h0001;
            osc_trim_strobe_o <= 1'b1;
            cal_cnt           <= CAL_CNT_RST;
         end else if (cal_cnt != 16'hffff) begin
            cal_cnt <= cal_cnt + 16'h0001;
         end
      end
   end

   // ==========================================================
   // Wake-frame comparison
   assign cfg_id = {rif.id_top, rif.id_umid, rif.id_lmid, rif.id_low[6:2]};

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wake_up_frame_match_o <= 1'b0;
      end else begin
         wake_up_frame_match_o <= 1'b0;
         if (frame_valid_i && wake_enabled
             && frame_ide_i == rif.id_low[ID_LOW_IDE_BIT]
             && frame_rtr_i == rif.id_low[ID_LOW_RTR_BIT]) begin
            if (rif.id_low[ID_LOW_IDE_BIT]) begin
               wake_up_frame_match_o <= frame_id_i == cfg_id;
            end else begin
               wake_up_frame_match_o <= frame_id_i[28:18] == cfg_id[28:18];
            end
         end
      end
   end

endmodule : can_selective_wake_config

// file: swk_cfg_pkg.sv
// Constants and types for the selective-wake configuration block
package wake_cfg_pkg;

   // ==========================================================
   // Register addresses (7-bit register space)
   localparam logic [6:0] ADDR_CTRL    = 7'h20;
   localparam logic [6:0] ADDR_QUANTA  = 7'h21;
   localparam logic [6:0] ADDR_SAMPLE  = 7'h22;
   localparam logic [6:0] ADDR_ID_TOP  = 7'h23;
   localparam logic [6:0] ADDR_ID_UMID = 7'h24;
   localparam logic [6:0] ADDR_ID_LMID = 7'h25;
   localparam logic [6:0] ADDR_ID_LOW  = 7'h26;
   localparam int         REG_COUNT    = 7;

   // ==========================================================
   // Field positions
   localparam int         CTRL_CAL_MODE_BIT = 7;
   localparam int         CTRL_KEY_HI      = 6;
   localparam int         CTRL_KEY_LO      = 5;
   localparam int         CTRL_TO_IRQ_BIT  = 4;
   localparam int         CTRL_VALID_BIT   = 0;
   localparam logic [1:0] UNLOCK_KEY       = 2'h3;
   localparam int         ID_LOW_RTR_BIT   = 1;
   localparam int         ID_LOW_IDE_BIT   = 0;

   // ==========================================================
   // Write masks (reserved bits read zero)
   localparam logic [7:0] CTRL_WMASK   = 8'hf1;
   localparam logic [7:0] SAMPLE_WMASK = 8'h3f;
   localparam logic [7:0] ID_LOW_WMASK = 8'h7f;
   localparam logic [7:0] FULL_WMASK   = 8'hff;

   // ==========================================================
   // Reset values
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] QUANTA_RST = 8'ha0;
   localparam logic [7:0] SAMPLE_RST = 8'h33;
   localparam logic [7:0] ID_RST     = 8'h00;
   localparam logic [7:0] OPTION_RST = 8'h00;
   localparam logic [7:0] CTRL_RESTART_KEEP = 8'hf0;

   // ==========================================================
   // Calibration tracker states
   typedef enum logic [2:0] {
      CAL_IDLE = 3'b001,
      CAL_LOW  = 3'b010,
      CAL_HIGH = 3'b100
   } cal_state_t;

   localparam logic [15:0] CAL_CNT_RST = 16'h0000;

endpackage : wake_cfg_pkg

// file: swk_reg_if.sv
// Register array access bundle between top and register store
`timescale 1ns/1ps
interface wake_reg_if;
   logic       wr_en;
   logic [2:0] wr_idx;
   logic [7:0] wr_data;
   logic [2:0] rd_idx;
   logic [7:0] rd_data;
   logic [7:0] ctrl;
   logic [7:0] quanta;
   logic [7:0] sample;
   logic [7:0] id_top;
   logic [7:0] id_umid;
   logic [7:0] id_lmid;
   logic [7:0] id_low;
   modport master (output wr_en, wr_idx, wr_data, rd_idx,
                   input rd_data, ctrl, quanta, sample, id_top, id_umid, id_lmid, id_low);
   modport store  (input wr_en, wr_idx, wr_data, rd_idx,
                   output rd_data, ctrl, quanta, sample, id_top, id_umid, id_lmid, id_low);
endinterface : wake_reg_if

// file: swk_reg_store.sv
// Configuration register store with power-on and restart behaviour
`timescale 1ns/1ps
module wake_reg_store
   import wake_cfg_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic resetn_i,
   input  wire logic soft_reset_i,
   input  wire logic restart_i,
   input  wire logic clear_valid_i,
   wake_reg_if.store bus
);

   logic [7:0] control;
   logic [7:0] regs [1:REG_COUNT-1];

   function automatic logic [7:0] wmask(input logic [2:0] idx);
      case (idx)
         3'd0:    wmask = CTRL_WMASK;
         3'd2:    wmask = SAMPLE_WMASK;
         3'd6:    wmask = ID_LOW_WMASK;
         default: wmask = FULL_WMASK;
      endcase
   endfunction : wmask

   // ==========================================================
   // Control register
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         control <= CTRL_RST;
      end else if (soft_reset_i) begin
         control <= CTRL_RST;
      end else if (restart_i) begin
         control <= control & CTRL_RESTART_KEEP;
      end else if (bus.wr_en && bus.wr_idx == 3'h0) begin
         control <= bus.wr_data & CTRL_WMASK;
      end else if (clear_valid_i) begin
         control[CTRL_VALID_BIT] <= 1'b0;
      end
   end

   // ==========================================================
   // Timing and identifier registers, kept through restart
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         regs[1] <= QUANTA_RST;
         regs[2] <= SAMPLE_RST;
         for (int i = 3; i < REG_COUNT; i++) begin
            regs[i] <= ID_RST;
         end
      end else if (soft_reset_i) begin
         regs[1] <= QUANTA_RST;
         regs[2] <= SAMPLE_RST;
         for (int i = 3; i < REG_COUNT; i++) begin
            regs[i] <= ID_RST;
         end
      end else if (bus.wr_en && bus.wr_idx != 3'd0 && bus.wr_idx < 3'd7) begin
         regs[bus.wr_idx] <= bus.wr_data & wmask(bus.wr_idx);
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus.rd_data <= 8'h00;
      end else if (bus.rd_idx == 3'h0) begin
         bus.rd_data <= control;
      end else if (bus.rd_idx < 3'h7) begin
         bus.rd_data <= regs[bus.rd_idx];
      end else begin
         bus.rd_data <= 8'h00;
      end
   end

   assign bus.ctrl    = control;
   assign bus.quanta  = regs[1];
   assign bus.sample  = regs[2];
   assign bus.id_top  = regs[3];
   assign bus.id_umid = regs[4];
   assign bus.id_lmid = regs[5];
   assign bus.id_low  = regs[6];

endmodule : wake_reg_store

// file: swk_config_monitor.sv
// Port-level assertions for the selective-wake configuration block
`timescale 1ns/1ps
module wake_config_monitor
   import wake_cfg_pkg::*;
(
   input wire logic        mclk_i,
   input wire logic        resetn_i,
   input wire logic        soft_reset_i,
   input wire logic        restart_i,
   input wire logic        reg_wr_i,
   input wire logic [6:0]  reg_addr_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic        wake_option_register_wr_i,
   input wire logic [7:0]  wake_option_register_data_i,
   input wire logic [7:0]  wake_option_register_o,
   input wire logic        selective_wake_enable_i,
   input wire logic        bus_timeout_event_i,
   input wire logic        bus_timeout_flag_o,
   input wire logic        interrupt_out_n_o,
   input wire logic        wake_up_event_i,
   input wire logic        frame_valid_i,
   input wire logic        wake_up_frame_match_o,
   input wire logic        selective_wake_active_o,
   input wire logic        recal_unlocked_o,
   input wire logic [7:0]  quanta_per_bit_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   wire wr_ctrl = reg_wr_i && reg_addr_i == ADDR_CTRL && !restart_i && !soft_reset_i;
   wire key_hit = reg_wdata_i[6:5] == UNLOCK_KEY;
   wire wr_cfg  = reg_wr_i && reg_addr_i >= ADDR_QUANTA && reg_addr_i <= ADDR_ID_LOW;
   wire opt_ok  = wake_option_register_wr_i && !soft_reset_i;
   wire fv_ok   = frame_valid_i && selective_wake_active_o;
   // ==========================================================
   // Properties
   property p_unlock; wr_ctrl |=> recal_unlocked_o == $past(key_hit); endproperty
   a_unlock: assert property (p_unlock) else $error("unlock flag wrong");
   property p_opt_lock;
      opt_ok && !recal_unlocked_o |=> $stable(wake_option_register_o);
   endproperty
   a_opt_lock: assert property (p_opt_lock) else $error("locked option changed");
   property p_opt_open;
      opt_ok && recal_unlocked_o |=> wake_option_register_o == $past(wake_option_register_data_i);
   endproperty
   a_opt_open: assert property (p_opt_open) else $error("option not written");
   property p_irq; !interrupt_out_n_o |-> $past(bus_timeout_flag_o); endproperty
   a_irq: assert property (p_irq) else $error("interrupt without flag");
   property p_to_set;
      bus_timeout_event_i && selective_wake_enable_i |=> bus_timeout_flag_o;
   endproperty
   a_to_set: assert property (p_to_set) else $error("flag not set");
   property p_to_gate;
      !selective_wake_enable_i && !bus_timeout_flag_o |=> !bus_timeout_flag_o;
   endproperty
   a_to_gate: assert property (p_to_gate) else $error("flag set while disabled");
   property p_active; selective_wake_active_o |-> selective_wake_enable_i; endproperty
   a_active: assert property (p_active) else $error("active without enable");
   property p_clear;
      wr_cfg || restart_i || (wake_up_event_i && !wr_ctrl) |=> !selective_wake_active_o;
   endproperty
   a_clear: assert property (p_clear) else $error("valid not cleared");
   property p_match; wake_up_frame_match_o |-> $past(fv_ok); endproperty
   a_match: assert property (p_match) else $error("match while inactive");
   property p_quanta;
      reg_wr_i && reg_addr_i == ADDR_QUANTA && !soft_reset_i
         |=> quanta_per_bit_o == $past(reg_wdata_i);
   endproperty
   a_quanta: assert property (p_quanta) else $error("quanta not written");
endmodule : wake_config_monitor

// file: swk_mcu_model.sv
// Microcontroller model driving the transmit data pin
`timescale 1ns/1ps
module wake_mcu_model #(
   parameter int HALF = 5
) (
   input  wire logic mclk_i,
   input  wire logic resetn_i,
   input  wire logic run_i,
   output logic      pin_o
);
   int cnt;
   // Square wave while calibrating, recessive high otherwise
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i || !run_i) begin
         cnt   <= 0;
         pin_o <= 1'b1;
      end else if (cnt == HALF - 1) begin
         cnt   <= 0;
         pin_o <= !pin_o;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : wake_mcu_model

// file: test_swk_config.sv
// Self-checking testbench for the selective-wake configuration block
`timescale 1ns/1ps
module test_can_selective_wake_config;
   import wake_cfg_pkg::*;
   localparam logic [4:0] P_RST = 5'h10, P_SOFT = 5'h08, P_TO = 5'h04;
   localparam logic [4:0] P_CLR = 5'h02, P_WAKE = 5'h01;
   logic        mclk_i = 1'b0, resetn_i = 1'b0, cal_run = 1'b0;
   logic [4:0]  pls = 5'h00;
   logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, wake_option_register_wr_i = 1'b0;
   logic [6:0]  reg_addr_i = 7'h00;
   logic [7:0]  reg_wdata_i = 8'h00, wake_option_register_data_i = 8'h00;
   logic        selective_wake_enable_i = 1'b0, frame_valid_i = 1'b0;
   logic        frame_ide_i = 1'b0, frame_rtr_i = 1'b0;
   logic [28:0] frame_id_i = 29'h0;
   wire         restart_i, soft_reset_i, bus_timeout_event_i, bus_timeout_clear_i;
   wire         wake_up_event_i, transmit_data_pin_i;
   wire  [7:0]  reg_rdata_o, wake_option_register_o, quanta_per_bit_o;
   wire  [5:0]  sample_point_fraction_o;
   wire  [15:0] osc_trim_period_o;
   wire         reg_rvalid_o, bus_timeout_flag_o, interrupt_out_n_o, osc_trim_strobe_o;
   wire         wake_up_frame_match_o, selective_wake_active_o, recal_unlocked_o;
   int          fail_count = 0;
   int          checked = 0;
   assign {restart_i, soft_reset_i, bus_timeout_event_i} = pls[4:2];
   assign {bus_timeout_clear_i, wake_up_event_i} = pls[1:0];
   always #50 mclk_i = ~mclk_i;
   can_selective_wake_config dut (.*);
   wake_mcu_model mcu (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .run_i    (cal_run),
      .pin_o    (transmit_data_pin_i)
   );
   // ==========================================================
   // Shared tasks
   task automatic finish_test();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic chkb(string n, logic e, logic s);
      chk(n, {15'h0, e}, {15'h0, s});
   endtask : chkb
   task automatic pulse(logic [4:0] m);
      @(posedge mclk_i);
      pls <= m;
      @(posedge mclk_i);
      pls <= 5'h00;
      @(negedge mclk_i);
   endtask : pulse
   task automatic en(logic b);
      @(posedge mclk_i);
      selective_wake_enable_i <= b;
      @(negedge mclk_i);
   endtask : en
   task automatic wr(logic [6:0] a, logic [7:0] d);
      @(posedge mclk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      @(negedge mclk_i);
   endtask : wr
   task automatic rd(logic [6:0] a, logic [7:0] e);
      @(posedge mclk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      @(negedge mclk_i);
      chkb("rvalid", 1'b1, reg_rvalid_o);
      chk("rdata", {8'h0, e}, {8'h0, reg_rdata_o});
   endtask : rd
   task automatic set_id(logic [28:0] id, logic ide);
      wr(ADDR_ID_TOP, id[28:21]);
      wr(ADDR_ID_UMID, id[20:13]);
      wr(ADDR_ID_LMID, id[12:5]);
      wr(ADDR_ID_LOW, {1'b0, id[4:0], 1'b0, ide});
      wr(ADDR_CTRL, 8'h01);
   endtask : set_id
   task automatic fr(logic [28:0] id, logic ide, logic rtr, logic e);
      @(posedge mclk_i);
      frame_valid_i <= 1'b1;
      frame_id_i <= id;
      frame_ide_i <= ide;
      frame_rtr_i <= rtr;
      @(posedge mclk_i);
      frame_valid_i <= 1'b0;
      @(negedge mclk_i);
      chkb("match", e, wake_up_frame_match_o);
   endtask : fr
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      for (int i = 0; i < REG_COUNT; i++) begin
         rd(ADDR_CTRL + 7'(i), i == 1 ? 8'ha0 : i == 2 ? 8'h33 : 8'h00);
      end
      rd(7'h27, 8'h00);
      wr(ADDR_QUANTA, 8'h5c);
      wr(ADDR_SAMPLE, 8'hff);
      wr(ADDR_ID_LOW, 8'hff);
      wr(ADDR_CTRL, 8'hff);
      rd(ADDR_CTRL, 8'hf1);
      rd(ADDR_SAMPLE, 8'h3f);
      rd(ADDR_ID_LOW, 8'h7f);
      chk("quanta", 16'h5c, {8'h0, quanta_per_bit_o});
      chk("sample", 16'h3f, {10'h0, sample_point_fraction_o});
      pulse(P_RST);
      rd(ADDR_CTRL, 8'hf0);
      rd(ADDR_QUANTA, 8'h5c);
      rd(ADDR_SAMPLE, 8'h3f);
      pulse(P_SOFT);
      rd(ADDR_CTRL, 8'h00);
      rd(ADDR_QUANTA, 8'ha0);
      rd(ADDR_SAMPLE, 8'h33);
   endtask : t_regs
   task automatic t_valid();
      en(1'b1);
      wr(ADDR_CTRL, 8'h01);
      chkb("active", 1'b1, selective_wake_active_o);
      en(1'b0);
      chkb("active", 1'b0, selective_wake_active_o);
      en(1'b1);
      pulse(P_WAKE);
      chkb("active", 1'b0, selective_wake_active_o);
      wr(ADDR_CTRL, 8'h01);
      wr(ADDR_ID_UMID, 8'h12);
      rd(ADDR_CTRL, 8'h00);
   endtask : t_valid
   task automatic t_frames();
      set_id(29'h0a5c3e97, 1'b1);
      fr(29'h0a5c3e97, 1'b1, 1'b0, 1'b1);
      fr(29'h0a5c3e96, 1'b1, 1'b0, 1'b0);
      fr(29'h0a5c3e97, 1'b1, 1'b1, 1'b0);
      fr(29'h0a5c3e97, 1'b0, 1'b0, 1'b0);
      set_id({11'h5a3, 18'h0}, 1'b0);
      fr({11'h5a3, 18'h2a5b1}, 1'b0, 1'b0, 1'b1);
      fr({11'h5a1, 18'h0}, 1'b0, 1'b0, 1'b0);
      pulse(P_WAKE);
      fr({11'h5a3, 18'h0}, 1'b0, 1'b0, 1'b0);
      wr(ADDR_CTRL, 8'h01);
      en(1'b0);
      fr({11'h5a3, 18'h0}, 1'b0, 1'b0, 1'b0);
   endtask : t_frames
   task automatic t_timeout();
      pulse(P_TO);
      chkb("flag", 1'b0, bus_timeout_flag_o);
      en(1'b1);
      wr(ADDR_CTRL, 8'h00);
      pulse(P_TO);
      chkb("flag", 1'b1, bus_timeout_flag_o);
      @(negedge mclk_i);
      chkb("irq_n", 1'b1, interrupt_out_n_o);
      pulse(P_CLR);
      wr(ADDR_CTRL, 8'h10);
      pulse(P_TO);
      @(negedge mclk_i);
      chkb("irq_n", 1'b0, interrupt_out_n_o);
      pulse(P_CLR);
   endtask : t_timeout
   task automatic t_option();
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_CTRL, {1'b0, 2'(k), 5'h00});
         chkb("unlock", k == 3, recal_unlocked_o);
         @(posedge mclk_i);
         wake_option_register_wr_i <= 1'b1;
         wake_option_register_data_i <= 8'h50 + 8'(k);
         @(posedge mclk_i);
         wake_option_register_wr_i <= 1'b0;
         @(negedge mclk_i);
         chk("option", k == 3 ? 16'h53 : 16'h00, {8'h0, wake_option_register_o});
      end
   endtask : t_option
   task automatic t_cal(logic [7:0] c, int exp_n);
      int n = 0;
      wr(ADDR_CTRL, c);
      @(posedge mclk_i);
      cal_run <= 1'b1;
      for (int i = 0; i < 80 && n == 0; i++) begin
         @(negedge mclk_i);
         n += int'(osc_trim_strobe_o === 1'b1);
      end
      chk("strobes", 16'(exp_n), 16'(n));
      if (exp_n == 1) begin
         chk("period", 16'd10, osc_trim_period_o);
      end
      @(posedge mclk_i);
      cal_run <= 1'b0;
   endtask : t_cal
   initial begin
      repeat (8) @(posedge mclk_i);
      resetn_i <= 1'b1;
      t_regs();
      t_valid();
      t_frames();
      t_timeout();
      t_option();
      t_cal(8'he0, 1);
      t_cal(8'h80, 0);
      t_cal(8'h60, 0);
      finish_test();
   end
endmodule : test_can_selective_wake_config
bind can_selective_wake_config wake_config_monitor mon (.*);
